// file: tom_map.svh
// tom_map.svh: offsets, field positions, reset values and timing counts
// for the dual-channel torque-off monitor.
// assumes inclusion by bare name from the package and the monitor module.
`ifndef TOM_MAP_SVH
`define TOM_MAP_SVH

// ==========================================================================
// register offsets (16-bit register port address)
`define TOM_ADDR_MODE 16'h4190
`define TOM_ADDR_DLY 16'h4191
`define TOM_ADDR_FN0 16'h4199
`define TOM_ADDR_FN1 16'h419A
`define TOM_ADDR_FN2 16'h419C
`define TOM_ADDR_STAT 16'h41A0

// ==========================================================================
// reset values and field encodings
`define TOM_MODE_RST 1'h0
`define TOM_MODE_LATCH 1'h0
`define TOM_MODE_ALMSD 1'h1
`define TOM_DLY_RST 8'h00
`define TOM_DLY_MIN 8'h0B
`define TOM_DLY_MAX 8'h64
`define TOM_FN_RST 8'h00
`define TOM_FN_TOC 8'h01
// status field positions
`define TOM_ST_A 0
`define TOM_ST_B 1
`define TOM_ST_MON 2
`define TOM_ST_ALM 3
`define TOM_ST_RDY 4
`define TOM_ST_STATE 5

// ==========================================================================
// timing
`define TOM_CLK_NS 5
`define TOM_MS_NS 1000000
`define TOM_BLINK_MS 8'h7D

`endif

// file: tom_pkg.sv
// tom_pkg.sv: types and shared helpers of the torque-off monitor.
// assumes tom_map.svh sits in the same folder.
`include "tom_map.svh"

package tom_pkg;

  // ========================================================================
  // control states, gray coded along normal -> alarm -> latched -> shutdown
  typedef enum logic [1:0] {
    TOM_NORMAL = 2'h0,
    TOM_CH_ALARM = 2'h1,
    TOM_LATCHED = 2'h3,
    TOM_ALM_SHUT = 2'h2
  } tom_state_type;

  // ========================================================================
  // off-to-on edge of a filtered level
  function automatic logic tom_rise(input logic prev, input logic cur);
    tom_rise = cur & ~prev;
  endfunction : tom_rise

endpackage : tom_pkg

// file: tom_sync.sv
// tom_sync.sv: three-stage input synchroniser with agreement filter.
// assumes asynchronous pin levels; output follows when stages 2 and 3 agree.
`timescale 1ns/100ps
`default_nettype none

module tom_sync
  import tom_pkg::*;
#(
  parameter int W = 6
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_stable
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] stable_next;

  // ========================================================================
  // agreement filter: a change counts only once stage 2 and 3 match
  always_comb begin
    stable_next = o_stable;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        stable_next[i] = s3_reg[i];
      end
    end
  end

  // stage 1 feeds stage 2 only, to keep metastability contained
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      o_stable <= '0;
    end else if (i_clk_en) begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      o_stable <= stable_next;
    end
  end

endmodule : tom_sync
`default_nettype wire

// file: tom_monitor.sv
// tom_monitor.sv: dual-channel external torque-off logic of a motor driver.
// assumes active-high pins (1 = input on), pins asynchronous to i_clock,
// and excitation/pulse-mode commands from logic on i_clock.
//
// Contract
// - either torque-off input going off cuts motor power, beside free-run.
// - the power cut is a direct gate on the pins, not a command path.
// - while torque-off from the inputs is active the indicator blinks green.
// - a brake motor has its brake engaged once power is removed.
// - the monitor output is on only while both inputs are off.
// - one input off raises the channel alarm if the delay is 11 to 100 ms.
// - both inputs off enter latched torque-off or alarm shutdown per mode.
// - both inputs off request torque-off; contacts are separate outside.
// - latched mode clears on an off-to-on edge of an assigned clear input.
// - latched mode never clears while either input is off.
// - alarm shutdown clears on the rising edge of the alarm clear input.
// - clearing with excitation present re-excites and raises ready at once.
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "tom_map.svh"

module tom_monitor
  import tom_pkg::*;
#(
  parameter int P_CYC_PER_MS = `TOM_MS_NS / `TOM_CLK_NS
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic i_torque_off_input_a,
  input wire logic i_torque_off_input_b,
  input wire logic i_alarm_clear_input,
  input wire logic [2:0] i_gp_input,
  input wire logic i_excite_cmd,
  input wire logic i_pulse_mode,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_motor_power_en,
  output logic o_brake_release,
  output logic o_shutoff_monitor_output,
  output logic o_power_alarm_indicator_green,
  output logic o_ch_alarm,
  output logic o_ready,
  output logic o_direct_command_ready_output,
  output logic o_pulse_command_ready_output
);

  // ========================================================================
  // synchronised pins
  logic [5:0] pin_stable;
  logic in_a;
  logic in_b;
  logic alm_clr;
  logic [2:0] gp;

  // three flops plus agreement before any decision except the raw-pin power gate
  tom_sync #(.W(6)) u_sync (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_clk_en(i_clk_en),
    .i_async({i_gp_input, i_alarm_clear_input,
              i_torque_off_input_b, i_torque_off_input_a}),
    .o_stable(pin_stable)
  );

  assign in_a = pin_stable[0];
  assign in_b = pin_stable[1];
  assign alm_clr = pin_stable[2];
  assign gp = pin_stable[5:3];

  // ========================================================================
  // register file
  logic mode_reg, mode_next;
  logic [7:0] dly_reg, dly_next;
  logic [7:0] fn_reg [3];
  logic [7:0] fn_next [3];
  logic [15:0] rdata_next;
  logic [15:0] status;

  // writes steer mode, delay and clear-input assignment; reads return state
  always_comb begin
    mode_next = mode_reg;
    dly_next = dly_reg;
    fn_next = fn_reg;
    rdata_next = 16'h0000;
    if (i_wr) begin
      case (i_addr)
        `TOM_ADDR_MODE: mode_next = i_wdata[0];
        `TOM_ADDR_DLY: dly_next = i_wdata[7:0];
        `TOM_ADDR_FN0: fn_next[0] = i_wdata[7:0];
        `TOM_ADDR_FN1: fn_next[1] = i_wdata[7:0];
        `TOM_ADDR_FN2: fn_next[2] = i_wdata[7:0];
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `TOM_ADDR_MODE: rdata_next = {15'h0000, mode_reg};
        `TOM_ADDR_DLY: rdata_next = {8'h00, dly_reg};
        `TOM_ADDR_FN0: rdata_next = {8'h00, fn_reg[0]};
        `TOM_ADDR_FN1: rdata_next = {8'h00, fn_reg[1]};
        `TOM_ADDR_FN2: rdata_next = {8'h00, fn_reg[2]};
        `TOM_ADDR_STAT: rdata_next = status;
        default: rdata_next = 16'h0000; // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_reg <= `TOM_MODE_RST;
      dly_reg <= `TOM_DLY_RST;
      fn_reg <= '{`TOM_FN_RST, `TOM_FN_RST, `TOM_FN_RST};
      o_rdata <= 16'h0000;
    end else if (i_clk_en) begin
      mode_reg <= mode_next;
      dly_reg <= dly_next;
      fn_reg <= fn_next;
      o_rdata <= rdata_next;
    end
  end

  // ========================================================================
  // millisecond tick, discrepancy timer and blink timer
  logic [17:0] pre_reg, pre_next;
  logic ms_tick;
  logic [7:0] disc_reg, disc_next;
  logic [7:0] blink_reg, blink_next;
  logic blink_on_reg, blink_on_next;
  logic one_off;
  logic dly_ok;

  assign ms_tick = (pre_reg == 18'(P_CYC_PER_MS - 1));
  assign one_off = in_a ^ in_b;
  assign dly_ok = (dly_reg >= `TOM_DLY_MIN) && (dly_reg <= `TOM_DLY_MAX);

  // discrepancy time runs only while exactly one channel is off
  always_comb begin
    pre_next = ms_tick ? 18'h0_0000 : pre_reg + 18'h0_0001;
    disc_next = disc_reg;
    if (!one_off) begin
      disc_next = 8'h00;
    end else if (ms_tick && disc_reg != 8'hFF) begin
      disc_next = disc_reg + 8'h01; // saturates, never wraps
    end
    blink_next = blink_reg;
    blink_on_next = blink_on_reg;
    if (ms_tick) begin
      if (blink_reg == `TOM_BLINK_MS - 8'h01) begin
        blink_next = 8'h00;
        blink_on_next = ~blink_on_reg;
      end else begin
        blink_next = blink_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_reg <= 18'h0_0000;
      disc_reg <= 8'h00;
      blink_reg <= 8'h00;
      blink_on_reg <= 1'b0;
    end else if (i_clk_en) begin
      pre_reg <= pre_next;
      disc_reg <= disc_next;
      blink_reg <= blink_next;
      blink_on_reg <= blink_on_next;
    end
  end

  // ========================================================================
  // torque-off state machine and registered outputs
  tom_state_type state_reg, state_next;
  logic alm_prev_reg;
  logic [2:0] gp_prev_reg;
  logic toc_edge;
  logic drive_en_reg, drive_en_next;
  logic mon_next, grn_next, rdy_next;

  // any input slot assigned the clear action may release latched mode
  always_comb begin
    toc_edge = 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (fn_reg[k] == `TOM_FN_TOC && tom_rise(gp_prev_reg[k], gp[k])) begin
        toc_edge = 1'b1;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TOM_NORMAL: begin
        if (one_off && dly_ok && disc_reg >= dly_reg) begin
          state_next = TOM_CH_ALARM;
        end
      end
      TOM_CH_ALARM: begin
        if (in_a && in_b && tom_rise(alm_prev_reg, alm_clr)) begin
          state_next = TOM_NORMAL;
        end
      end
      TOM_LATCHED: begin
        if (in_a && in_b && toc_edge) begin
          state_next = TOM_NORMAL;
        end
      end
      TOM_ALM_SHUT: begin
        if (in_a && in_b && tom_rise(alm_prev_reg, alm_clr)) begin
          state_next = TOM_NORMAL;
        end
      end
      default: state_next = TOM_NORMAL;
    endcase
    // both off is the torque-off request and overrides everything
    if (!in_a && !in_b) begin
      state_next = (mode_reg == `TOM_MODE_LATCH) ? TOM_LATCHED
                                                 : TOM_ALM_SHUT;
    end
    // excitation follows in the very step that leaves torque-off
    drive_en_next = (state_next == TOM_NORMAL) && in_a && in_b
                    && i_excite_cmd;
    rdy_next = drive_en_next;
    mon_next = !in_a && !in_b;
    // blink while any channel holds power removed
    grn_next = (!in_a || !in_b || state_next == TOM_LATCHED
                || state_next == TOM_ALM_SHUT) ? blink_on_reg : 1'b1;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= TOM_NORMAL;
      alm_prev_reg <= 1'b0;
      gp_prev_reg <= 3'h0;
      drive_en_reg <= 1'b0;
      o_brake_release <= 1'b0;
      o_shutoff_monitor_output <= 1'b0;
      o_power_alarm_indicator_green <= 1'b0;
      o_ch_alarm <= 1'b0;
      o_ready <= 1'b0;
      o_direct_command_ready_output <= 1'b0;
      o_pulse_command_ready_output <= 1'b0;
    end else if (i_clk_en) begin
      state_reg <= state_next;
      alm_prev_reg <= alm_clr;
      gp_prev_reg <= gp;
      drive_en_reg <= drive_en_next;
      o_brake_release <= drive_en_next; // brake holds when unpowered
      o_shutoff_monitor_output <= mon_next;
      o_power_alarm_indicator_green <= grn_next;
      o_ch_alarm <= (state_next == TOM_CH_ALARM);
      o_ready <= rdy_next;
      o_direct_command_ready_output <= rdy_next && !i_pulse_mode;
      o_pulse_command_ready_output <= rdy_next && i_pulse_mode;
    end
  end

  // ========================================================================
  // power gate: raw pins AND the registered enable; a pin going off cuts
  // power with no clock, so a stopped clock cannot hold the motor on
  always_comb begin
    o_motor_power_en = i_torque_off_input_a && i_torque_off_input_b
                       && drive_en_reg;
  end

  // status word for software
  always_comb begin
    status = 16'h0000;
    status[`TOM_ST_A] = in_a;
    status[`TOM_ST_B] = in_b;
    status[`TOM_ST_MON] = o_shutoff_monitor_output;
    status[`TOM_ST_ALM] = o_ch_alarm;
    status[`TOM_ST_RDY] = o_ready;
    status[`TOM_ST_STATE +: 2] = state_reg;
  end

endmodule : tom_monitor
`default_nettype wire

// file: tom_monitor_props.sv
// tom_monitor_props.sv: port assertions of the torque-off monitor.
// assumes bind to tom_monitor with P_CYC_PER_MS handed on.
`timescale 1ns/100ps
`default_nettype none
module tom_monitor_props #(
  parameter int P_CYC_PER_MS = 4
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_torque_off_input_a,
  input wire logic i_torque_off_input_b,
  input wire logic o_motor_power_en,
  input wire logic o_brake_release,
  input wire logic o_shutoff_monitor_output,
  input wire logic o_power_alarm_indicator_green,
  input wire logic o_ch_alarm,
  input wire logic o_ready,
  input wire logic o_direct_command_ready_output,
  input wire logic o_pulse_command_ready_output
);
  // ==========================================================================
  // helper: cycles the indicator stood still with monitor on
  localparam int BLINK_MAX = 126 * P_CYC_PER_MS + 2;
  wire logic a_on = i_torque_off_input_a;
  wire logic b_on = i_torque_off_input_b;
  wire logic ab_off = !a_on && !b_on;
  int hold_reg;
  int hold_next;
  logic led_reg;
  // count resets on each toggle, so it never exceeds a half period
  always_comb begin
    hold_next = 0;
    if (o_shutoff_monitor_output && o_power_alarm_indicator_green == led_reg)
      hold_next = hold_reg + 1;
  end
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hold_reg <= 0;
      led_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      led_reg <= o_power_alarm_indicator_green;
    end
  end
  // ==========================================================================
  // assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  AST_PWR_CUT: assert property (!(a_on && b_on) |-> !o_motor_power_en)
    else $error("motor power on with a channel off");
  AST_MON_ON: assert property (ab_off [*8] |-> o_shutoff_monitor_output)
    else $error("monitor off with both channels off");
  AST_MON_OFF: assert property (!ab_off [*8] |-> !o_shutoff_monitor_output)
    else $error("monitor on with a channel on");
  AST_HALT: assert property (ab_off [*8] |-> !o_brake_release && !o_ready)
    else $error("brake or ready wrong in torque off");
  AST_RDY_SPLIT: assert property ((o_direct_command_ready_output ||
    o_pulse_command_ready_output) == o_ready && !(o_direct_command_ready_output
    && o_pulse_command_ready_output))
    else $error("ready outputs disagree");
  AST_RDY_BOTH_ON: assert property ($rose(o_ready) |->
    $past(a_on, 4) && $past(b_on, 4))
    else $error("ready rose with a channel off");
  AST_ALM_ONE: assert property ($rose(o_ch_alarm) |->
    $past(a_on, 4) != $past(b_on, 4))
    else $error("channel alarm without discrepancy");
  AST_BLINK: assert property (hold_reg <= BLINK_MAX)
    else $error("indicator did not blink");
  COV_OFF: cover property (ab_off [*8]);
  COV_ALM: cover property ($rose(o_ch_alarm));
  COV_RDY: cover property ($rose(o_ready));
endmodule : tom_monitor_props
bind tom_monitor tom_monitor_props #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_props (
  .i_clock(i_clock), .i_arst_n(i_arst_n),
  .i_torque_off_input_a(i_torque_off_input_a),
  .i_torque_off_input_b(i_torque_off_input_b),
  .o_motor_power_en(o_motor_power_en), .o_brake_release(o_brake_release),
  .o_shutoff_monitor_output(o_shutoff_monitor_output),
  .o_power_alarm_indicator_green(o_power_alarm_indicator_green),
  .o_ch_alarm(o_ch_alarm), .o_ready(o_ready),
  .o_direct_command_ready_output(o_direct_command_ready_output),
  .o_pulse_command_ready_output(o_pulse_command_ready_output));
`default_nettype wire

// file: tom_contacts.sv
// tom_contacts.sv: external safety contacts and their fault watcher.
// assumes requests from the bench; pins move one edge after a request.
`timescale 1ns/100ps
`default_nettype none
module tom_contacts (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_want_a,
  input wire logic i_want_b,
  input wire logic i_want_clr,
  input wire logic i_want_gp0,
  input wire logic i_monitor,
  output logic o_pin_a,
  output logic o_pin_b,
  output logic o_pin_clr,
  output logic [2:0] o_pin_gp,
  output logic o_fault
);
  int calm = 0;
  // ==========================================================================
  // each channel has its own contact, no shared wiring
  // pins follow the bench requests one edge later, one process for all pins
  always @(posedge i_clock) begin
    o_pin_a <= i_want_a;
    o_pin_b <= i_want_b;
    o_pin_clr <= i_want_clr;
    o_pin_gp <= {2'h0, i_want_gp0};
    calm <= (!i_arst_n || i_want_a != o_pin_a || i_want_b != o_pin_b) ? 0
      : calm + 1;
  end
  // settled pins must match the monitor, else flag a fault
  always @(negedge i_clock) begin
    if (!i_arst_n)
      o_fault <= 1'b0;
    else if (calm > 8 && i_monitor !== (!o_pin_a && !o_pin_b))
      o_fault <= 1'b1;
  end
endmodule : tom_contacts
`default_nettype wire

// file: tom_tb.sv
// tom_tb.sv: self-checking bench of the torque-off monitor.
// assumes P_CYC_PER_MS of 4, so one ms is four cycles.
`timescale 1ns/100ps
`default_nettype none
`include "tom_map.svh"
module tb;
  logic i_clock, i_arst_n, i_excite_cmd, i_pulse_mode, i_wr, i_rd, rd_d, pm;
  logic want_a, want_b, want_clr, want_gp0;
  logic [15:0] i_addr, i_wdata;
  logic [31:0] exp_q[$];
  wire logic pin_a, pin_b, pin_clr, fault, pwr, brk, mon, led, alm, rdy;
  wire logic drdy, prdy;
  wire logic [2:0] pin_gp;
  wire logic [15:0] o_rdata;
  int n_errors, compares, dly, tg;
  logic l0;
  tom_monitor #(.P_CYC_PER_MS(4)) dut (.i_clock(i_clock),
    .i_arst_n(i_arst_n), .i_clk_en(1'b1), .i_torque_off_input_a(pin_a),
    .i_torque_off_input_b(pin_b), .i_alarm_clear_input(pin_clr),
    .i_gp_input(pin_gp), .i_excite_cmd(i_excite_cmd),
    .i_pulse_mode(i_pulse_mode), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_motor_power_en(pwr),
    .o_brake_release(brk), .o_shutoff_monitor_output(mon),
    .o_power_alarm_indicator_green(led), .o_ch_alarm(alm), .o_ready(rdy),
    .o_direct_command_ready_output(drdy),
    .o_pulse_command_ready_output(prdy));
  tom_contacts u_contacts (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_want_a(want_a), .i_want_b(want_b), .i_want_clr(want_clr),
    .i_want_gp0(want_gp0), .i_monitor(mon), .o_pin_a(pin_a),
    .o_pin_b(pin_b), .o_pin_clr(pin_clr), .o_pin_gp(pin_gp),
    .o_fault(fault));
  // ==========================================================================
  // shared tasks
  task automatic tally_and_finish();
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic check_word(input logic [15:0] got, input logic [31:0] e);
    compares++;
    if ((got & e[31:16]) !== e[15:0]) begin
      n_errors++;
      $display("unexpected at %0t: read %h want %h", $time, got, e[15:0]);
    end
  endtask : check_word
  task automatic check_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: flag %b want %b", $time, got, exp);
    end
  endtask : check_flag
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask : cyc
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    cyc(1);
    i_wr <= 1'b0;
    cyc(1);
  endtask : wr
  // expected value noted first, compared when the answer stands
  task automatic rd(input logic [15:0] a, input logic [15:0] e,
      input logic [15:0] m);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back({m, e});
    cyc(1);
    i_rd <= 1'b0;
    cyc(1);
  endtask : rd
  // rising edge on gp slot 0 (sel 0) or on the alarm clear pin (sel 1)
  task automatic pulse(input bit sel);
    want_clr <= 1'b0;
    want_gp0 <= 1'b0;
    cyc(6);
    if (sel)
      want_clr <= 1'b1;
    else
      want_gp0 <= 1'b1;
    cyc(8);
  endtask : pulse
  // ==========================================================================
  // clock, read monitor and watchdog
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) rd_d <= i_rd;
  always @(negedge i_clock) begin
    if (rd_d === 1'b1)
      check_word(o_rdata, exp_q.pop_front());
  end
  initial begin
    #100_000;
    n_errors++;
    tally_and_finish();
  end
  // ==========================================================================
  // main sequence
  initial begin
    {i_arst_n, i_excite_cmd, i_pulse_mode, i_wr, i_rd} = 5'h00;
    {want_a, want_b, want_clr, want_gp0} = 4'hc;
    i_addr = 16'h0000;
    i_wdata = 16'h0000;
    n_errors = 0;
    compares = 0;
    dly = $urandom(32'h0000_3d88);
    dly = 11 + $urandom % 90;
    pm = 1'($urandom % 2);
    cyc(8);
    i_arst_n <= 1'b1;
    cyc(10);
    rd(`TOM_ADDR_STAT, 16'h0063, 16'h007f);
    wr(`TOM_ADDR_FN0, 16'h0001);
    wr(`TOM_ADDR_DLY, dly[15:0]);
    rd(`TOM_ADDR_DLY, dly[15:0], 16'hffff);
    rd(16'h4000, 16'h0000, 16'hffff);
    wr(`TOM_ADDR_FN1, 16'h0001);
    rd(`TOM_ADDR_FN1, 16'h0001, 16'hffff);
    i_pulse_mode <= pm;
    i_excite_cmd <= 1'b1;
    pulse(0);
    check_flag(rdy, 1'b1);
    check_flag(pwr, 1'b1);
    check_flag(brk, 1'b1);
    check_flag(drdy, !pm);
    check_flag(prdy, pm);
    rd(`TOM_ADDR_STAT, 16'h0013, 16'h007f);
    // one channel off: cut at once, monitor still off
    want_b <= 1'b0;
    cyc(2);
    #1;
    check_flag(pwr, 1'b0);
    check_flag(mon, 1'b0);
    cyc(dly * 4 - 4);
    check_flag(alm, 1'b0);
    cyc(20);
    check_flag(alm, 1'b1);
    rd(`TOM_ADDR_STAT, 16'h0029, 16'h007f);
    // both off with the motor already commanded still
    i_excite_cmd <= 1'b0;
    want_a <= 1'b0;
    cyc(10);
    check_flag(mon, 1'b1);
    check_flag(brk, 1'b0);
    rd(`TOM_ADDR_STAT, 16'h0064, 16'h0077);
    tg = 0;
    l0 = led;
    repeat (600) begin
      @(negedge i_clock);
      tg += (led !== l0);
      l0 = led;
    end
    cyc(1);
    check_flag(tg > 0, 1'b1);
    // clear edge while one channel is still off is ignored
    want_a <= 1'b1;
    pulse(0);
    rd(`TOM_ADDR_STAT, 16'h0061, 16'h0077);
    want_b <= 1'b1;
    cyc(8);
    pulse(1);
    pulse(0);
    rd(`TOM_ADDR_STAT, 16'h0003, 16'h0077);
    // alarm shutdown mode, cleared by the alarm clear edge
    wr(`TOM_ADDR_MODE, 16'h0001);
    i_excite_cmd <= 1'b1;
    want_a <= 1'b0;
    want_b <= 1'b0;
    cyc(10);
    rd(`TOM_ADDR_STAT, 16'h0044, 16'h0077);
    want_a <= 1'b1;
    want_b <= 1'b1;
    cyc(8);
    pulse(1);
    check_flag(rdy, 1'b1);
    rd(`TOM_ADDR_STAT, 16'h0013, 16'h0077);
    check_flag(fault, 1'b0);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
